//--- rtl/internal_error_injection.sv
// Software error injection for the internal errors of one port, with an AXI4-Lite register bank.
`timescale 1ns/1ns

module internal_error_injection
	import err_inj_pkg::*;
#(
	parameter bit HAS_DMA = 1'b1
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	// AXI4-Lite write address channel.
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output wire logic              awready,
	// AXI4-Lite write data channel.
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [STRB_W-1:0] wstrb,
	input  wire logic              wvalid,
	output wire logic              wready,
	// AXI4-Lite write response channel.
	output wire logic [1:0]        bresp,
	output wire logic              bvalid,
	input  wire logic              bready,
	// AXI4-Lite read address channel.
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output wire logic              arready,
	// AXI4-Lite read data channel.
	output wire logic [DATA_W-1:0] rdata,
	output wire logic [1:0]        rresp,
	output wire logic              rvalid,
	input  wire logic              rready,
	// Genuine error events from the port's own detectors.
	input  wire logic [31:0]       realErrorIn,
	// Event strobes toward the internal error status register.
	output wire logic [31:0]       errorLogged,
	// Reports toward the bridge error reporting structure.
	output wire logic              aerCorrectable,
	output wire logic              aerUncorrectable,
	// Level interrupt.
	output wire logic              irq
);

	// Bits that map to a defined internal error, outside the DMA engine.
	localparam logic [31:0] PORT_BITS =
		(TO_GROUP << INB_TO_LSB)
		| (TO_GROUP << OUTB_TO_LSB)
		| (MEM_GROUP << INB_MEM_LSB)
		| (MEM_GROUP << OUTB_MEM_LSB)
		| (ONE_BIT << PARITY_BIT)
		| (ONE_BIT << LINK_BIT)
		| (PAIR_GROUP << RETRY_LSB);

	// Bits that map to DMA engine errors.
	localparam logic [31:0] DMA_BITS =
		(TO_GROUP << DMA_TO_LSB)
		| (DMA_MEM << DMA_MEM_LSB)
		| (ONE_BIT << DMA_PARITY_BIT);

	// Reserved bits 3, 22, 29 and 30 are in neither set, so they are never injected.
	localparam logic [31:0] INJECTABLE = HAS_DMA ? (PORT_BITS | DMA_BITS) : PORT_BITS;

	typedef struct packed {
		logic              awHeld;
		logic              wHeld;
		logic [ADDR_W-1:0] awAddr;
		logic [DATA_W-1:0] wData;
		logic [STRB_W-1:0] wStrb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic [31:0]       inject;
		logic [31:0]       severity;
		logic [31:0]       bridgeMask;
		logic [31:0]       irqSts;
		logic [31:0]       irqMsk;
		logic              irq;
	} top_state_t;

	localparam top_state_t RESET_STATE = '{
		awHeld:     1'b0,
		wHeld:      1'b0,
		awAddr:     '0,
		wData:      '0,
		wStrb:      '0,
		awready:    1'b0,
		wready:     1'b0,
		bvalid:     1'b0,
		bresp:      RESP_OKAY,
		arready:    1'b0,
		rvalid:     1'b0,
		rdata:      '0,
		rresp:      RESP_OKAY,
		inject:     '0,
		severity:   SEV_RESET,
		bridgeMask: BMASK_RESET,
		irqSts:     '0,
		irqMsk:     IRQ_MSK_RESET,
		irq:        1'b0
	};

	top_state_t q;
	top_state_t d;

	// Word match of a byte address against a register offset; low two bits are ignored.
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] ofs);
		hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction : hit

	// Registers of the bank, as seen by the write and read paths.
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_SEV,
		SEL_INJ_LOWER,
		SEL_INJ_UPPER,
		SEL_BMASK,
		SEL_IRQ_STS,
		SEL_IRQ_MSK
	} reg_sel_t;

	// One decoder serves both paths, so a read can never see a different map than a write.
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
		if (hit(addr, SEV_OFS)) begin
			decode = SEL_SEV;
		end else if (hit(addr, INJ_LOWER_OFS)) begin
			decode = SEL_INJ_LOWER;
		end else if (hit(addr, INJ_UPPER_OFS)) begin
			decode = SEL_INJ_UPPER;
		end else if (hit(addr, BMASK_OFS)) begin
			decode = SEL_BMASK;
		end else if (hit(addr, IRQ_STS_OFS)) begin
			decode = SEL_IRQ_STS;
		end else if (hit(addr, IRQ_MSK_OFS)) begin
			decode = SEL_IRQ_MSK;
		end else begin
			decode = SEL_NONE;
		end
	endfunction : decode

	// Merge write data into a register under the byte strobes.
	function automatic logic [31:0] merge(
		input logic [31:0]       old,
		input logic [31:0]       data,
		input logic [STRB_W-1:0] strb
	);
		logic [31:0] laneMask;
		laneMask = '0;
		for (int i = 0; i < STRB_W; i++) begin
			laneMask[i*8 +: 8] = {8{strb[i]}};
		end
		merge = (old & ~laneMask) | (data & laneMask);
	endfunction : merge

	err_report_if rpt ();

	logic [31:0] errEvent;
	logic [31:0] rdClear;
	reg_sel_t    wrSel;
	reg_sel_t    rdSel;

	// Injected and genuine errors share one path, so an injection is logged exactly like a
	// real fault, including severity selection and bridge masking downstream.
	assign errEvent       = q.inject | realErrorIn;
	assign rpt.errEvent   = errEvent;
	assign rpt.severity   = q.severity;
	assign rpt.bridgeMask = q.bridgeMask;

	// The write decodes its held address; the read decodes the address as it is offered.
	assign wrSel          = decode(q.awAddr);
	assign rdSel          = decode(araddr);

	err_reporter u_reporter (
		.core_clk (core_clk),
		.rst      (rst),
		.rp       (rpt.rpt)
	);

	// Next-state logic for the bus slave, injection triggers and interrupt status.
	always_comb begin
		d        = q;
		rdClear  = '0;
		// Triggers last one cycle; nothing holds them, so they read back as zero.
		d.inject = '0;

		// Address and data may arrive in either order; each is held until both are in.
		if (awvalid && q.awready) begin
			d.awHeld = 1'b1;
			d.awAddr = awaddr;
		end
		if (wvalid && q.wready) begin
			d.wHeld = 1'b1;
			d.wData = wdata;
			d.wStrb = wstrb;
		end

		// Perform the write once both halves are held and no response is pending.
		if (q.awHeld && q.wHeld && !q.bvalid) begin
			d.awHeld = 1'b0;
			d.wHeld  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = RESP_OKAY;
			case (wrSel)
				SEL_INJ_LOWER: begin
					// Only ones fire; zeros and reserved or absent DMA bits do nothing.
					d.inject = merge('0, q.wData, q.wStrb) & INJECTABLE;
				end
				SEL_INJ_UPPER: begin
					// Fully reserved word: the write completes but changes nothing.
					d.bresp = RESP_OKAY;
				end
				SEL_SEV: begin
					d.severity = merge(q.severity, q.wData, q.wStrb);
				end
				SEL_BMASK: begin
					d.bridgeMask = merge(q.bridgeMask, q.wData, q.wStrb);
				end
				SEL_IRQ_MSK: begin
					d.irqMsk = merge(q.irqMsk, q.wData, q.wStrb);
				end
				SEL_IRQ_STS: begin
					// Status clears only by reading; a write is accepted and ignored.
					d.bresp = RESP_OKAY;
				end
				default: begin
					d.bresp = RESP_DECERR;
				end
			endcase
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end

		// Reads answer one cycle after the address is taken.
		if (arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp  = RESP_OKAY;
			case (rdSel)
				SEL_INJ_LOWER: begin
					d.rdata = '0;
				end
				SEL_INJ_UPPER: begin
					d.rdata = '0;
				end
				SEL_SEV: begin
					d.rdata = q.severity;
				end
				SEL_BMASK: begin
					d.rdata = q.bridgeMask;
				end
				SEL_IRQ_STS: begin
					d.rdata = q.irqSts;
					rdClear = '1;
				end
				SEL_IRQ_MSK: begin
					d.rdata = q.irqMsk;
				end
				default: begin
					d.rdata = '0;
					d.rresp = RESP_DECERR;
				end
			endcase
		end
		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end

		// An event in the same cycle as the clearing read survives it.
		d.irqSts = (q.irqSts & ~rdClear) | errEvent;
		d.irq    = |(d.irqSts & d.irqMsk);

		// Readies are registered, so they drop for the cycle a transfer is being finished.
		d.awready = !d.awHeld && !d.bvalid;
		d.wready  = !d.wHeld && !d.bvalid;
		d.arready = !d.rvalid;
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= RESET_STATE;
		end else begin
			q <= d;
		end
	end

	// All outputs are register outputs.
	assign awready          = q.awready;
	assign wready           = q.wready;
	assign bvalid           = q.bvalid;
	assign bresp            = q.bresp;
	assign arready          = q.arready;
	assign rvalid           = q.rvalid;
	assign rdata            = q.rdata;
	assign rresp            = q.rresp;
	assign errorLogged      = rpt.logged;
	assign aerCorrectable   = rpt.aerCor;
	assign aerUncorrectable = rpt.aerUnc;
	assign irq              = q.irq;

endmodule : internal_error_injection

//--- common/err_inj_pkg.sv
// Package holding the register map, field positions and reset values of the error injector.
package err_inj_pkg;

	// Bus geometry.
	localparam int          ADDR_W  = 12;
	localparam int          DATA_W  = 32;
	localparam int          STRB_W  = DATA_W / 8;

	// Register byte offsets.
	localparam logic [11:0] SEV_OFS       = 12'h490;
	localparam logic [11:0] INJ_LOWER_OFS = 12'h494;
	localparam logic [11:0] INJ_UPPER_OFS = 12'h498;
	localparam logic [11:0] BMASK_OFS     = 12'h4a0;
	localparam logic [11:0] IRQ_STS_OFS   = 12'h4c0;
	localparam logic [11:0] IRQ_MSK_OFS   = 12'h4c4;

	// Field positions inside the injection, severity and mask words.
	localparam int          INB_TO_LSB     = 0;
	localparam int          OUTB_TO_LSB    = 4;
	localparam int          INB_MEM_LSB    = 7;
	localparam int          OUTB_MEM_LSB   = 11;
	localparam int          PARITY_BIT     = 15;
	localparam int          LINK_BIT       = 16;
	localparam int          RETRY_LSB      = 17;
	localparam int          DMA_TO_LSB     = 19;
	localparam int          DMA_MEM_LSB    = 23;
	localparam int          DMA_PARITY_BIT = 31;

	// Field widths of the grouped triggers.
	localparam logic [31:0] TO_GROUP   = 32'h0000_0007;
	localparam logic [31:0] MEM_GROUP  = 32'h0000_000f;
	localparam logic [31:0] PAIR_GROUP = 32'h0000_0003;
	localparam logic [31:0] DMA_MEM    = 32'h0000_003f;
	localparam logic [31:0] ONE_BIT    = 32'h0000_0001;

	// Reset values.
	localparam logic [31:0] SEV_RESET     = 32'h9000_0000;
	localparam logic [31:0] BMASK_RESET   = 32'h0000_0000;
	localparam logic [31:0] IRQ_MSK_RESET = 32'h0000_0000;

	// AXI4-Lite response codes.
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_DECERR = 2'h3;

endpackage : err_inj_pkg

//--- common/err_report_if.sv
// Interface carrying error events and their reporting controls to the reporter.
`timescale 1ns/1ns
interface err_report_if;
	logic [31:0] errEvent;
	logic [31:0] severity;
	logic [31:0] bridgeMask;
	logic [31:0] logged;
	logic        aerCor;
	logic        aerUnc;

	modport src (
		output errEvent,
		output severity,
		output bridgeMask,
		input  logged,
		input  aerCor,
		input  aerUnc
	);

	modport rpt (
		input  errEvent,
		input  severity,
		input  bridgeMask,
		output logged,
		output aerCor,
		output aerUnc
	);
endinterface : err_report_if

//--- rtl/err_reporter.sv
// Reporter that turns error events into status pulses and correctable or uncorrectable reports.
`timescale 1ns/1ns
module err_reporter
	import err_inj_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	err_report_if.rpt rp
);

	typedef struct packed {
		logic [31:0] logged;
		logic        aerCor;
		logic        aerUnc;
	} rpt_state_t;

	rpt_state_t q;
	rpt_state_t d;

	// Every event reaches the status path; only unmasked ones reach the bridge report.
	always_comb begin
		d        = q;
		d.logged = rp.errEvent;
		d.aerUnc = |(rp.errEvent & rp.severity & ~rp.bridgeMask);
		d.aerCor = |(rp.errEvent & ~rp.severity & ~rp.bridgeMask);
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rp.logged = q.logged;
	assign rp.aerCor = q.aerCor;
	assign rp.aerUnc = q.aerUnc;

endmodule : err_reporter

//--- verification/internal_error_injection_asserts.sv
// Checker of bus answers and injection timing at the injector's ports.
`timescale 1ns/1ns
module internal_error_injection_asserts
	import err_inj_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [STRB_W-1:0] wstrb,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [1:0]        rresp,
	input wire logic              rvalid,
	input wire logic              rready,
	input wire logic [31:0]       errorLogged,
	input wire logic              aerCorrectable,
	input wire logic              aerUncorrectable,
	input wire logic              irq
);
	// One clock domain, so reset disables every check in one place.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Bus answers stand until taken and arrive within a short bound.
	a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before it was taken");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
		else $error("write response missing");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data missing one cycle after address");
	a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data changed before it was taken");
	// The trigger register and the reserved one always read back as zero.
	a_inj_reads_zero: assert property (arvalid && arready && araddr == INJ_LOWER_OFS
		|=> rdata == 32'h0 && rresp == RESP_OKAY) else $error("trigger register read nonzero");
	a_upper_reads_zero: assert property (arvalid && arready && araddr == INJ_UPPER_OFS
		|=> rdata == 32'h0 && rresp == RESP_OKAY) else $error("reserved register read nonzero");
	// A trigger of the link error must reach the status path promptly.
	a_inj_logs_link: assert property (awvalid && awready && wvalid && wready
		&& awaddr == INJ_LOWER_OFS && wstrb == 4'hf && wdata[16] |-> ##[1:4] errorLogged[16])
		else $error("link error trigger not logged");
	a_aer_has_event: assert property (aerCorrectable || aerUncorrectable |-> errorLogged != 32'h0)
		else $error("report without a logged event");

	c_link_logged: cover property (errorLogged[16]);
	c_uncorrectable: cover property (aerUncorrectable);
	c_irq_raised: cover property (irq);
endmodule : internal_error_injection_asserts

bind internal_error_injection internal_error_injection_asserts chk (.*);

//--- verification/tb_top.sv
// Self-checking bench for the error injector, driven over its register bus.
`timescale 1ns/1ns
module tb_top;
	import err_inj_pkg::*;
	logic              core_clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, rvalid, arready, irq;
	logic              aerCorrectable, aerUncorrectable, corSeen, uncSeen;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [1:0]        bresp, rresp, rs;
	logic [3:0]        wstrb;
	logic [31:0]       wdata, rdata, realErrorIn, errorLogged, logSeen, rd;
	logic [31:0]       noDmaLogged, noDmaSeen;
	int                failures, check_count;
	// Bits that name an error, and those uncorrectable after reset.
	localparam logic [31:0] DEFINED = 32'h9fbf_fff7;
	localparam logic [31:0] UNC_RST = 32'h9000_0000;
	// Bits that name an error on a port without the DMA function.
	localparam logic [31:0] NO_DMA  = 32'h0007_fff7;

	internal_error_injection dut (.*);

	// A port without DMA sees the same traffic, so its handshakes track the main instance.
	internal_error_injection #(
		.HAS_DMA (1'b0)
	) dutNoDma (
		.core_clk         (core_clk),
		.rst              (rst),
		.awaddr           (awaddr),
		.awvalid          (awvalid),
		.awready          (),
		.wdata            (wdata),
		.wstrb            (wstrb),
		.wvalid           (wvalid),
		.wready           (),
		.bresp            (),
		.bvalid           (),
		.bready           (bready),
		.araddr           (araddr),
		.arvalid          (arvalid),
		.arready          (),
		.rdata            (),
		.rresp            (),
		.rvalid           (),
		.rready           (rready),
		.realErrorIn      (realErrorIn),
		.errorLogged      (noDmaLogged),
		.aerCorrectable   (),
		.aerUncorrectable (),
		.irq              ()
	);

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Pulses are gathered on the falling edge so clearing never races them.
	always @(negedge core_clk) begin
		logSeen |= errorLogged;
		noDmaSeen |= noDmaLogged;
		corSeen |= aerCorrectable;
		uncSeen |= aerUncorrectable;
	end

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, bresp});
	endtask : wr

	task rdr(input logic [11:0] a);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rdr

	// Late pulses of an earlier write must not leak into the next check.
	task clr;
		repeat (8) @(posedge core_clk);
		logSeen = 32'h0;
		noDmaSeen = 32'h0;
		corSeen = 1'b0;
		uncSeen = 1'b0;
	endtask : clr

	task inject(input logic [31:0] d);
		clr();
		wr(INJ_LOWER_OFS, d);
		repeat (6) @(posedge core_clk);
	endtask : inject

	task t_reset_values;
		rdr(SEV_OFS);
		chk("severity", UNC_RST, rd);
		rdr(BMASK_OFS);
		chk("bridge mask", 32'h0, rd);
		rdr(INJ_UPPER_OFS);
		chk("upper", 32'h0, rd);
		rdr(12'h010);
		chk("unmapped resp", {30'h0, RESP_DECERR}, {30'h0, rs});
	endtask : t_reset_values

	task t_each_bit;
		for (int i = 0; i < 32; i++) begin
			inject(32'h1 << i);
			chk("logged", DEFINED & (32'h1 << i), logSeen);
			chk("no dma logged", NO_DMA & (32'h1 << i), noDmaSeen);
			chk("unc", {31'h0, DEFINED[i] & UNC_RST[i]}, {31'h0, uncSeen});
			chk("cor", {31'h0, DEFINED[i] & ~UNC_RST[i]}, {31'h0, corSeen});
		end
	endtask : t_each_bit

	task t_readback;
		inject(32'hffff_ffff);
		chk("all logged", DEFINED, logSeen);
		rdr(INJ_LOWER_OFS);
		chk("trigger read", 32'h0, rd);
		clr();
		wr(INJ_UPPER_OFS, 32'hffff_ffff);
		repeat (6) @(posedge core_clk);
		chk("upper logged", 32'h0, logSeen);
		inject(32'h0);
		chk("zero logged", 32'h0, logSeen);
	endtask : t_readback

	task t_mask_sev;
		wr(BMASK_OFS, 32'h1);
		wr(SEV_OFS, 32'h0);
		inject(32'h1);
		chk("masked logged", 32'h1, logSeen);
		chk("masked reports", 32'h0, {30'h0, corSeen, uncSeen});
		wr(BMASK_OFS, 32'h0);
		wr(SEV_OFS, 32'h1);
		inject(32'h1);
		chk("unc reports", 32'h1, {30'h0, corSeen, uncSeen});
	endtask : t_mask_sev

	task t_irq;
		rdr(IRQ_STS_OFS);
		wr(IRQ_MSK_OFS, 32'h0001_0000);
		inject(32'h1);
		chk("irq masked", 32'h0, {31'h0, irq});
		inject(32'h0001_0000);
		chk("irq", 32'h1, {31'h0, irq});
		rdr(IRQ_STS_OFS);
		chk("status", 32'h0001_0001, rd);
		repeat (3) @(posedge core_clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
	endtask : t_irq

	task t_real;
		clr();
		realErrorIn <= 32'h0000_8000;
		@(posedge core_clk);
		realErrorIn <= 32'h0;
		repeat (6) @(posedge core_clk);
		chk("real logged", 32'h0000_8000, logSeen);
	endtask : t_real

	task final_report;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report

	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata, realErrorIn} = '0;
		{logSeen, noDmaSeen, corSeen, uncSeen} = '0;
		wstrb = 4'hf;
		failures = 0;
		check_count = 0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		t_reset_values();
		t_each_bit();
		t_readback();
		t_mask_sev();
		t_irq();
		t_real();
		final_report();
	end

	// A hang far past the expected run of under a thousand cycles ends the run.
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		final_report();
	end
endmodule : tb_top
